// ### huf_defines.vh
// Purpose: constants for the host serial port with hardware flow control
// Assumes: 200 MHz mclk, 8 data bits by default
// Notes: bit period is set by the baud divisor input
`ifndef HUF_DEFINES_VH
`define HUF_DEFINES_VH
`define HUF_DATA_BITS      8
`define HUF_FIFO_DEPTH     32
`define HUF_FIFO_AW        5
`define HUF_DIV_W          16
`define HUF_DIV_RESET      16'h0032
`define HUF_BIT_W          4
`define HUF_ST_IDLE        3'h0
`define HUF_ST_START       3'h1
`define HUF_ST_DATA        3'h2
`define HUF_ST_PARITY      3'h3
`define HUF_ST_STOP        3'h4
`endif

// ### huf_fifo.v
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes: full and empty come from a pointer one bit wider than the address
`timescale 1ns/1ps
`default_nettype none
module huf_fifo #(
    parameter WIDTH = 8,
    parameter AW    = 5
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire             ce,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];
    reg [AW:0]      wp_r;
    reg [AW:0]      rp_r;
    wire            do_wr;
    wire            do_rd;

    assign level     = wp_r - rp_r;
    assign in_ready  = (level != (1 << AW));
    assign out_valid = (level != {(AW+1){1'b0}});
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always @* begin
        out_data = mem[rp_r[AW-1:0]];
    end

    always @(posedge mclk) begin
        if (reset) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (do_wr) begin
                mem[wp_r[AW-1:0]] <= in_data;
                wp_r <= wp_r + 1'b1;
            end
            if (do_rd) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### huf_tx.v
// Purpose: serial transmitter, one character per accepted word
// Assumes: divisor at least 2 clocks
// Notes: cts is sampled only between characters, so a started frame completes
`timescale 1ns/1ps
`default_nettype none
`include "huf_defines.vh"
module huf_tx #(
    parameter DW = `HUF_DATA_BITS,
    parameter DIVW = `HUF_DIV_W
) (
    input  wire            mclk,
    input  wire            reset,
    input  wire            ce,
    input  wire [DIVW-1:0] divisor,
    input  wire            parity_en,
    input  wire            parity_odd,
    input  wire            flow_en,
    input  wire            cts_high,
    input  wire [DW-1:0]   data,
    input  wire            valid,
    output wire            ready,
    output reg             txd,
    output wire            busy
);
    reg [2:0]      st_r;
    reg [DIVW-1:0] cnt_r;
    reg [3:0]      bit_r;
    reg [DW-1:0]   sh_r;
    reg            par_r;
    wire           tick;

    assign tick  = (cnt_r == divisor - 1'b1);
    // hold off new characters while host throttles; the current one finishes
    // a frozen port must not look ready, or the word offered would be lost
    assign ready = ce && (st_r == `HUF_ST_IDLE) && !(flow_en && cts_high);
    assign busy  = (st_r != `HUF_ST_IDLE);

    always @(posedge mclk) begin
        if (reset) begin
            st_r  <= `HUF_ST_IDLE;
            cnt_r <= {DIVW{1'b0}};
            bit_r <= 4'h0;
            sh_r  <= {DW{1'b0}};
            par_r <= 1'b0;
            txd   <= 1'b1;
        end else if (ce) begin
            cnt_r <= (st_r == `HUF_ST_IDLE || tick) ? {DIVW{1'b0}} : cnt_r + 1'b1;
            case (st_r)
                `HUF_ST_IDLE: begin
                    txd <= 1'b1;
                    if (valid && ready) begin
                        sh_r  <= data;
                        par_r <= (^data) ^ parity_odd;
                        txd   <= 1'b0;
                        st_r  <= `HUF_ST_START;
                    end
                end
                `HUF_ST_START: begin
                    if (tick) begin
                        txd   <= sh_r[0];
                        sh_r  <= sh_r >> 1;
                        bit_r <= 4'h0;
                        st_r  <= `HUF_ST_DATA;
                    end
                end
                `HUF_ST_DATA: begin
                    if (tick) begin
                        if (bit_r == DW - 1) begin
                            txd  <= parity_en ? par_r : 1'b1;
                            st_r <= parity_en ? `HUF_ST_PARITY : `HUF_ST_STOP;
                        end else begin
                            txd   <= sh_r[0];
                            sh_r  <= sh_r >> 1;
                            bit_r <= bit_r + 1'b1;
                        end
                    end
                end
                `HUF_ST_PARITY: begin
                    if (tick) begin
                        txd  <= 1'b1;
                        st_r <= `HUF_ST_STOP;
                    end
                end
                `HUF_ST_STOP: begin
                    if (tick) begin
                        st_r <= `HUF_ST_IDLE;
                    end
                end
                default: st_r <= `HUF_ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### huf_uart.v
// Purpose: host-facing serial port with rts/cts hardware flow control
// Assumes: rxd and cts_n are pins from the host, synchronised here
// Notes: receiver samples mid-bit from the start edge, so drift must stay under half a bit by mid stop bit
`timescale 1ns/1ps
`default_nettype none
`include "huf_defines.vh"
module huf_uart #(
    parameter DW    = `HUF_DATA_BITS,
    parameter AW    = `HUF_FIFO_AW,
    parameter DIVW  = `HUF_DIV_W
) (
    input  wire            mclk,
    input  wire            reset,
    input  wire            ce,
    input  wire [DIVW-1:0] divisor,
    input  wire            parity_en,
    input  wire            parity_odd,
    input  wire            flow_en,
    input  wire            rxd,
    output wire            txd,
    input  wire            cts_n,
    output reg             rts_n,
    input  wire [DW-1:0]   tx_data,
    input  wire            tx_valid,
    output wire            tx_ready,
    output wire [DW-1:0]   rx_data,
    output wire            rx_valid,
    input  wire            rx_ready,
    output reg             rx_parity_err,
    output reg             rx_frame_err,
    output reg             rx_overrun,
    output wire            tx_busy
);
    reg            rxd_m_r;
    reg            rxd_s_r;
    reg            cts_m_r;
    reg            cts_s_r;
    reg [2:0]      st_r;
    reg [DIVW-1:0] cnt_r;
    reg [3:0]      bit_r;
    reg [DW-1:0]   sh_r;
    reg            par_r;
    reg [DW-1:0]   wr_data_r;
    reg            wr_valid_r;
    wire           wr_ready;
    wire [AW:0]    level;
    wire [DIVW-1:0] half;
    wire           tick;
    wire           mid;

    always @(posedge mclk) begin
        if (reset) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            cts_m_r <= 1'b1;
            cts_s_r <= 1'b1;
        end else if (ce) begin
            rxd_m_r <= rxd;
            rxd_s_r <= rxd_m_r;
            cts_m_r <= cts_n;
            cts_s_r <= cts_m_r;
        end
    end

    huf_tx #(
        .DW   (DW),
        .DIVW (DIVW)
    ) u_tx (
        .mclk       (mclk),
        .reset      (reset),
        .ce         (ce),
        .divisor    (divisor),
        .parity_en  (parity_en),
        .parity_odd (parity_odd),
        .flow_en    (flow_en),
        .cts_high   (cts_s_r),
        .data       (tx_data),
        .valid      (tx_valid),
        .ready      (tx_ready),
        .txd        (txd),
        .busy       (tx_busy)
    );

    huf_fifo #(
        .WIDTH (DW),
        .AW    (AW)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .ce        (ce),
        .in_data   (wr_data_r),
        .in_valid  (wr_valid_r),
        .in_ready  (wr_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .level     (level)
    );

    // quarter-full threshold leaves 24 free slots, above the 16 the host may still send
    always @(posedge mclk) begin
        if (reset) begin
            rts_n <= 1'b1;
        end else if (ce) begin
            rts_n <= (level >= ((1 << AW) >> 2));
        end
    end

    assign half = {1'b0, divisor[DIVW-1:1]};
    assign tick = (cnt_r == divisor - 1'b1);
    assign mid  = (cnt_r == half);

    // every bit is resampled at its own centre from a counter restarted at the
    // start edge, so drift only accumulates within one character
    always @(posedge mclk) begin
        if (reset) begin
            st_r          <= `HUF_ST_IDLE;
            cnt_r         <= {DIVW{1'b0}};
            bit_r         <= 4'h0;
            sh_r          <= {DW{1'b0}};
            par_r         <= 1'b0;
            wr_data_r     <= {DW{1'b0}};
            wr_valid_r    <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_frame_err  <= 1'b0;
            rx_overrun    <= 1'b0;
        end else if (ce) begin
            wr_valid_r    <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_frame_err  <= 1'b0;
            rx_overrun    <= 1'b0;
            cnt_r <= (st_r == `HUF_ST_IDLE || tick) ? {DIVW{1'b0}} : cnt_r + 1'b1;
            case (st_r)
                `HUF_ST_IDLE: begin
                    if (!rxd_s_r) begin
                        st_r <= `HUF_ST_START;
                    end
                end
                `HUF_ST_START: begin
                    if (mid) begin
                        // glitch shorter than half a bit is not a start bit
                        if (rxd_s_r) begin
                            st_r <= `HUF_ST_IDLE;
                        end
                    end
                    if (tick) begin
                        bit_r <= 4'h0;
                        par_r <= parity_odd;
                        st_r  <= `HUF_ST_DATA;
                    end
                end
                `HUF_ST_DATA: begin
                    if (mid) begin
                        sh_r  <= {rxd_s_r, sh_r[DW-1:1]};
                        par_r <= par_r ^ rxd_s_r;
                    end
                    if (tick) begin
                        if (bit_r == DW - 1) begin
                            st_r <= parity_en ? `HUF_ST_PARITY : `HUF_ST_STOP;
                        end else begin
                            bit_r <= bit_r + 1'b1;
                        end
                    end
                end
                `HUF_ST_PARITY: begin
                    if (mid) begin
                        par_r <= par_r ^ rxd_s_r;
                    end
                    if (tick) begin
                        st_r <= `HUF_ST_STOP;
                    end
                end
                `HUF_ST_STOP: begin
                    // finish at mid stop bit to resync early for a fast sender
                    if (mid) begin
                        wr_data_r     <= sh_r;
                        wr_valid_r    <= wr_ready;
                        rx_overrun    <= !wr_ready;
                        rx_frame_err  <= !rxd_s_r;
                        rx_parity_err <= parity_en && par_r;
                        st_r          <= `HUF_ST_IDLE;
                    end
                end
                default: st_r <= `HUF_ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### huf_uart_monitor.sv
// Purpose: pin-level checks on the host serial port
// Assumes: bench runs divisor 16, so a character fits in MAX_CHAR cycles
// Notes: bound into huf_uart by port name
`timescale 1ns/1ps
`default_nettype none
module huf_uart_monitor #(
    parameter DW   = 8,
    parameter DIVW = 16
) (
    input wire logic            mclk,
    input wire logic            reset,
    input wire logic [DIVW-1:0] divisor,
    input wire logic            flow_en,
    input wire logic            txd,
    input wire logic            cts_n,
    input wire logic            rts_n,
    input wire logic            tx_valid,
    input wire logic            tx_ready,
    input wire logic [DW-1:0]   rx_data,
    input wire logic            rx_valid,
    input wire logic            rx_ready,
    input wire logic            tx_busy
);
    localparam int MAX_CHAR = 200;
    logic [DIVW-1:0] start_cnt_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // counts the start bit, txd lags the accept by one cycle
    always @(posedge mclk) begin
        if (reset)
            start_cnt_r <= '0;
        else if (tx_valid && tx_ready)
            start_cnt_r <= DIVW'(1);
        else if (start_cnt_r != 0 && start_cnt_r < divisor - 1'b1)
            start_cnt_r <= start_cnt_r + 1'b1;
        else
            start_cnt_r <= '0;
    end
    a_idle_high: assert property (!tx_busy |-> txd)
        else $error("txd low while idle");
    a_start_low: assert property (start_cnt_r != 0 |=> !txd)
        else $error("start bit too short");
    a_frame_busy: assert property (tx_valid && tx_ready |=> tx_busy [*8])
        else $error("frame ended early");
    a_stop_high: assert property ($fell(tx_busy) |-> txd && $past(txd, 2))
        else $error("stop bit not high");
    a_cts_block: assert property ((flow_en && cts_n) [*3] |-> !tx_ready)
        else $error("accept while host holds off");
    a_char_end: assert property ((flow_en && cts_n) [*3] ##0 tx_busy |-> ##[1:MAX_CHAR] !tx_busy)
        else $error("transmit not stopped within a character");
    a_rts_empty: assert property (!rx_valid [*2] |-> !rts_n)
        else $error("rts high with empty buffer");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("buffered word lost");
    c_accept: cover property (tx_valid && tx_ready);
    c_rts: cover property ($rose(rts_n));
    c_pop: cover property (rx_valid && rx_ready);
endmodule
bind huf_uart huf_uart_monitor #(.DW(DW), .DIVW(DIVW)) huf_uart_monitor_inst (
    .mclk     (mclk),
    .reset    (reset),
    .divisor  (divisor),
    .flow_en  (flow_en),
    .txd      (txd),
    .cts_n    (cts_n),
    .rts_n    (rts_n),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_ready (rx_ready),
    .tx_busy  (tx_busy)
);
`default_nettype wire

// ### huf_host_model.sv
// Purpose: host side serial port with hold-off line
// Assumes: shares the divisor and parity settings of the port under test
// Notes: rxd rests high after a frame, as the pull-up would leave it
`timescale 1ns/1ps
`default_nettype none
module huf_host_model (
    input  wire logic        mclk,
    input  wire logic        txd,
    input  wire logic [15:0] divisor,
    input  wire logic        parity_en,
    input  wire logic        parity_odd,
    output var  logic        rxd,
    output var  logic        cts_n
);
    logic [7:0] got_byte;
    logic       got_par;
    logic       got_stop;
    int         got_cnt;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
        got_cnt = 0;
    end
    always begin
        @(negedge txd);
        repeat (divisor / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (divisor) @(posedge mclk);
            got_byte[i] = txd;
        end
        if (parity_en) begin
            repeat (divisor) @(posedge mclk);
            got_par = txd;
        end
        repeat (divisor) @(posedge mclk);
        got_stop = txd;
        got_cnt++;
    end
    // dev stretches or shrinks one data bit only, so the whole character stays near rate
    // bad flips the parity bit, or with parity off sends a low stop bit
    task automatic send(input logic [7:0] d, input int dev, input logic bad);
        logic [10:0] bits;
        bits = parity_en ? {1'b1, (parity_odd ? ~^d : ^d) ^ bad, d, 1'b0} : {1'b1, !bad, d, 1'b0};
        for (int k = 0; k < (parity_en ? 11 : 10); k++) begin
            rxd = bits[k];
            repeat (int'(divisor) + (k == 1 ? dev : 0)) @(negedge mclk);
        end
        rxd = 1'b1;
    endtask
    task automatic cts_hold(input logic v);
        cts_n = v;
        if (v)
            repeat (divisor) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the host serial port
// Assumes: divisor 16, inputs change on the falling edge
// Notes: every wait is bounded
`timescale 1ns/1ps
`default_nettype none
`define HM huf_host_model_inst
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
`define WAIT(c, lim) begin n = 0; while ((c) !== 1'b1 && n < lim) begin @(negedge mclk); n++; end if ((c) !== 1'b1) begin num_errors++; $display("mismatch at %0t: timeout", $time); end_of_test(); end end
module tb;
    logic        mclk, reset, ce, parity_en, parity_odd, flow_en, tx_valid, rx_ready;
    logic [15:0] divisor;
    logic [7:0]  tx_data;
    wire  logic  rxd, txd, cts_n, rts_n, tx_ready, rx_valid, tx_busy;
    wire  logic  rx_parity_err, rx_frame_err, rx_overrun;
    wire  logic [7:0] rx_data;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          n;
    int          perr_cnt = 0;
    int          ferr_cnt = 0;
    int          ovr_cnt = 0;
    // error flags are one-cycle pulses, so count them where they stand
    always @(negedge mclk) begin
        if (rx_parity_err !== 1'b0) perr_cnt++;
        if (rx_frame_err !== 1'b0) ferr_cnt++;
        if (rx_overrun !== 1'b0) ovr_cnt++;
    end
    huf_uart huf_uart_inst (.mclk(mclk), .reset(reset), .ce(ce), .divisor(divisor), .parity_en(parity_en),
        .parity_odd(parity_odd), .flow_en(flow_en), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun),
        .tx_busy(tx_busy));
    huf_host_model huf_host_model_inst (.mclk(mclk), .txd(txd), .divisor(divisor), .parity_en(parity_en),
        .parity_odd(parity_odd), .rxd(rxd), .cts_n(cts_n));
    task automatic end_of_test;
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_tx(input logic [7:0] d, input logic pe, input logic po);
        int c0;
        c0 = `HM.got_cnt;
        parity_en = pe;
        parity_odd = po;
        tx_data = d;
        tx_valid = 1'b1;
        `WAIT(tx_ready, 50)
        @(negedge mclk);
        tx_valid = 1'b0;
        `WAIT(`HM.got_cnt != c0, 400)
        `CHK(`HM.got_byte, d)
        if (pe) `CHK(`HM.got_par, po ? ~^d : ^d)
        `CHK(`HM.got_stop, 1'b1)
    endtask
    task automatic pop(input logic [7:0] d);
        `WAIT(rx_valid, 100)
        `CHK(rx_data, d)
        rx_ready = 1'b1;
        @(negedge mclk);
        rx_ready = 1'b0;
        @(negedge mclk);
    endtask
    task automatic t_rx(input logic [7:0] d, input int dev, input logic pe, input logic po, input logic bad);
        int p0;
        int f0;
        p0 = perr_cnt;
        f0 = ferr_cnt;
        parity_en = pe;
        parity_odd = po;
        `HM.send(d, dev, bad);
        pop(d);
        `CHK(perr_cnt - p0, (pe && bad) ? 1 : 0)
        `CHK(ferr_cnt - f0, (!pe && bad) ? 1 : 0)
        // let a false start after a low stop bit die out
        repeat (20) @(negedge mclk);
    endtask
    task automatic t_ce;
        ce = 1'b0;
        tx_data = 8'h5a;
        tx_valid = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK(tx_ready, 1'b0)
        `CHK(tx_busy, 1'b0)
        `CHK(txd, 1'b1)
        tx_valid = 1'b0;
        ce = 1'b1;
        @(negedge mclk);
    endtask
    // host starts at once and sends one past the threshold, well inside 16
    task automatic t_rts;
        for (int k = 0; k < 9; k++) begin
            `HM.send(8'h40 + k[7:0], 0, 1'b0);
            if (k == 6) `CHK(rts_n, 1'b0)
            if (k == 7) `CHK(rts_n, 1'b1)
        end
        for (int k = 0; k < 9; k++)
            pop(8'h40 + k[7:0]);
        repeat (2) @(negedge mclk);
        `CHK(rts_n, 1'b0)
        `CHK(ovr_cnt, 0)
    endtask
    task automatic t_cts;
        int c0;
        c0 = `HM.got_cnt;
        flow_en = 1'b1;
        tx_data = 8'h96;
        tx_valid = 1'b1;
        `WAIT(tx_busy, 50)
        `HM.cts_hold(1'b1);
        `WAIT(`HM.got_cnt != c0, 250)
        repeat (40) @(negedge mclk);
        `CHK(tx_busy, 1'b0)
        `CHK(tx_ready, 1'b0)
        `HM.cts_hold(1'b0);
        `WAIT(tx_busy, 50)
        tx_valid = 1'b0;
        `WAIT(`HM.got_cnt == c0 + 2, 400)
        `CHK(`HM.got_byte, 8'h96)
        flow_en = 1'b0;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        divisor = 16'h0010;
        {parity_en, parity_odd, flow_en, tx_valid, rx_ready} = 5'h00;
        tx_data = 8'h00;
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        t_tx(8'ha5, 1'b0, 1'b0);
        t_tx(8'h3c, 1'b1, 1'b0);
        t_tx(8'h81, 1'b1, 1'b1);
        t_rx(8'hc3, -2, 1'b1, 1'b1, 1'b0);
        t_rx(8'h5e, 2, 1'b0, 1'b0, 1'b0);
        t_rx(8'h69, 0, 1'b1, 1'b0, 1'b1);
        t_rx(8'ha7, 0, 1'b0, 1'b0, 1'b1);
        t_rts;
        t_ce;
        t_cts;
        end_of_test;
    end
endmodule
`default_nettype wire
